/* rtl/pfc_llc_seq_pkg.sv */
// Summary of operation
// - check level-one overcurrent once per switching cycle
// - threshold by phase: 550, 750, 427.5 mV
// - normal threshold never in softstart or burst
// - overcurrent forces the limiting switching frequency
// - below threshold, step frequency down from limit
// - feedback (in softstart: timed) frequency above limit returns control
// - count detections, act at limit, default eight
// - level-two comparator puts system into auto-restart in softstart and normal
// - level-two comparator status kept readable
// - initialize, load setup, then enable both stages
// - correction stage disabled: no sensing, gate low
// - check open loop before correction softstart
// - softstart limits integrator, normal near rated bus
// - overcurrent continues; overvoltage pauses, resumes at once
// - long conduction mode restarts correction through softstart
// - half-bridge disabled: no sensing, both gates low
// - wait for startup bus, then timed softstart
// - feedback frequency reaches timed frequency: normal state
// - undervoltage to bus check; faults restart after pause
// - blanked overcurrent ends pulse; restart on crossing/timeout
// - suppress pulse when requested on-time below minimum
// - softstart steps every 512 us, shrinking steps
package pfc_llc_seq_pkg;
   // clock and widths
   localparam int CLK_FREQ_MHZ = 125;
   localparam int PERIOD_W = 16;
   localparam int SENSE_W = 12;
   localparam int ONTIME_W = 12;
   localparam int CNT_W = 27;
   localparam int EVT_W = 4;
   // timing figures in their own units and derived cycle counts
   localparam int SS_STEP_TIME_US = 512;
   localparam int SS_STEP_CYCLES = SS_STEP_TIME_US * CLK_FREQ_MHZ;
   localparam int RESTART_PAUSE_MS = 1000;
   localparam int RESTART_PAUSE_CYCLES = RESTART_PAUSE_MS * 1000 * CLK_FREQ_MHZ;
   localparam int OC_BLANK_TIME_NS = 200;
   localparam int OC_BLANK_CYCLES = (OC_BLANK_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int PFC_MAX_PERIOD_US = 20;
   localparam int PFC_MAX_PERIOD_CYCLES = PFC_MAX_PERIOD_US * CLK_FREQ_MHZ;
   localparam logic [4:0] INIT_LOAD_CYCLES = 5'h10;
   // shunt sense codes, 500 uV per lsb
   localparam int SENSE_LSB_UV = 500;
   localparam logic [SENSE_W-1:0] OC1_TH_STARTUP = SENSE_W'(550000 / SENSE_LSB_UV);
   localparam logic [SENSE_W-1:0] OC1_TH_BURST = SENSE_W'(750000 / SENSE_LSB_UV);
   localparam logic [SENSE_W-1:0] OC1_TH_NORMAL = SENSE_W'(427500 / SENSE_LSB_UV);
   localparam logic [EVT_W-1:0] OC1_EVENT_LIMIT_DEFAULT = 4'h8;
   // comparator pin positions in the synchroniser vector
   localparam int PIN_N = 5;
   localparam int PIN_OC2 = 0;
   localparam int PIN_ZCD = 1;
   localparam int PIN_PFC_OC = 2;
   localparam int PIN_BUS_OVERVOLTAGE_FIRST = 3;
   localparam int PIN_BUS_OVERVOLTAGE_SECOND = 4;
   // half-bridge stage states
   typedef enum logic [2:0] {
      HB_DISABLED = 3'b000,
      HB_BUS_CHECK = 3'b001,
      HB_SOFTSTART = 3'b010,
      HB_NORMAL = 3'b011,
      HB_RESTART = 3'b100
   } hb_state_t;
   // correction stage states
   typedef enum logic [2:0] {
      PFC_DISABLED = 3'b000,
      PFC_LOOP_CHECK = 3'b001,
      PFC_SOFTSTART = 3'b010,
      PFC_NORMAL = 3'b011,
      PFC_OV_PAUSE = 3'b100,
      PFC_RESTART = 3'b101
   } pfc_state_t;
endpackage : pfc_llc_seq_pkg

/* rtl/pfc_llc_protection_sequencer.sv */
`timescale 1ns/1ps
module pfc_llc_protection_sequencer #(
   parameter int SS_STEP_CYCLES = pfc_llc_seq_pkg::SS_STEP_CYCLES,
   parameter int RESTART_PAUSE_CYCLES = pfc_llc_seq_pkg::RESTART_PAUSE_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   // comparator pins, asynchronous to clk
   input wire logic hb_overcurrent_level_two,
   input wire logic zero_crossing_detect,
   input wire logic correction_current_sense,
   input wire logic bus_overvoltage_first,
   input wire logic bus_overvoltage_second,
   // sampled values and flags from same-clock logic
   input wire logic [pfc_llc_seq_pkg::SENSE_W-1:0] hb_shunt_sense,
   input wire logic [pfc_llc_seq_pkg::SENSE_W-1:0] bus_voltage_sense,
   input wire logic [pfc_llc_seq_pkg::PERIOD_W-1:0] hb_feedback_input,
   input wire logic [pfc_llc_seq_pkg::ONTIME_W-1:0] correction_on_request,
   input wire logic burst_active,
   input wire logic burst_exit,
   input wire logic hb_open_loop,
   input wire logic hb_overload,
   input wire logic correction_ccm_fault,
   input wire logic oc2_event_clear,
   // setup values, captured during initialization
   input wire logic [pfc_llc_seq_pkg::PERIOD_W-1:0] oc1_limit_frequency,
   input wire logic [pfc_llc_seq_pkg::EVT_W-1:0] oc1_event_limit,
   input wire logic [pfc_llc_seq_pkg::ONTIME_W-1:0] correction_min_on_time,
   input wire logic [pfc_llc_seq_pkg::SENSE_W-1:0] hb_startup_bus_level,
   // setup values used directly
   input wire logic [pfc_llc_seq_pkg::PERIOD_W-1:0] oc1_release_step,
   input wire logic [pfc_llc_seq_pkg::PERIOD_W-1:0] tco_start_period,
   input wire logic [pfc_llc_seq_pkg::PERIOD_W-1:0] tco_initial_step,
   input wire logic [pfc_llc_seq_pkg::PERIOD_W-1:0] tco_min_step,
   input wire logic [pfc_llc_seq_pkg::SENSE_W-1:0] hb_undervoltage_level,
   input wire logic [pfc_llc_seq_pkg::SENSE_W-1:0] bus_open_loop_level,
   input wire logic [pfc_llc_seq_pkg::SENSE_W-1:0] bus_near_rated_level,
   // gate drive and status
   output logic hb_high_gate,
   output logic hb_low_gate,
   output logic hb_sense_enable,
   output logic [pfc_llc_seq_pkg::PERIOD_W-1:0] hb_switch_period,
   output logic hb_oc1_limiting,
   output logic hb_oc2_status,
   output logic hb_oc2_event,
   output logic correction_gate,
   output logic correction_sense_enable,
   output logic correction_integrator_limit,
   output logic system_restart_active
);
   import pfc_llc_seq_pkg::*;
   // cycle limits at register width
   localparam logic [CNT_W-1:0] SS_STEP_LAST = CNT_W'(SS_STEP_CYCLES - 1);
   localparam logic [CNT_W-1:0] RESTART_LAST = CNT_W'(RESTART_PAUSE_CYCLES - 1);
   localparam logic [4:0] OC_BLANK = 5'(OC_BLANK_CYCLES);
   localparam logic [ONTIME_W-1:0] PFC_MAX_PERIOD = ONTIME_W'(PFC_MAX_PERIOD_CYCLES);
   // complete state of the sequencer
   typedef struct packed {
      logic [PIN_N-1:0] sync1; // first synchroniser stage
      logic [PIN_N-1:0] sync2; // second stage
      logic [PIN_N-1:0] sync3; // third stage
      logic [PIN_N-1:0] pin; // accepted levels
      logic [4:0] init_cnt; // setup load counter
      logic init_done; // stages enabled
      logic [PERIOD_W-1:0] oc1_period; // captured limiting period
      logic [EVT_W-1:0] oc1_limit; // captured event limit
      logic [ONTIME_W-1:0] min_on; // captured minimum on-time
      logic [SENSE_W-1:0] hb_start_lvl; // captured startup bus level
      hb_state_t hb_state; // half-bridge state
      logic [PERIOD_W-1:0] hb_period; // half-period in use
      logic [PERIOD_W-1:0] hb_cnt; // half-period counter
      logic hb_half; // 0 high half, 1 low half
      logic hb_high; // high-side gate
      logic hb_low; // low-side gate
      logic [PERIOD_W-1:0] tco_period; // timed oscillator period
      logic [PERIOD_W-1:0] tco_step; // present step size
      logic [CNT_W-1:0] ss_timer; // softstart step timer
      logic oc1_active; // limiting active
      logic [PERIOD_W-1:0] oc1_run; // imposed period
      logic [EVT_W-1:0] oc1_count; // detections so far
      logic [CNT_W-1:0] sys_pause; // system restart pause
      logic oc2_event; // sticky level-two flag
      pfc_state_t pfc_state; // correction state
      logic [CNT_W-1:0] pfc_pause; // correction restart pause
      logic pfc_gate; // correction gate
      logic [ONTIME_W-1:0] pfc_on_cnt; // remaining on-time
      logic [ONTIME_W-1:0] pfc_off_cnt; // time since pulse end
      logic [4:0] pfc_oc_cnt; // blanking count
      logic zcd_prev; // zero crossing memory
   } state_t;
   state_t q;
   state_t next_q;
   // saturating add for period stepping
   function automatic logic [PERIOD_W-1:0] sat_add(input logic [PERIOD_W-1:0] a, input logic [PERIOD_W-1:0] b);
      logic [PERIOD_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[PERIOD_W] ? {PERIOD_W{1'b1}} : s[PERIOD_W-1:0];
   endfunction : sat_add
   // level-one threshold for the present phase
   function automatic logic [SENSE_W-1:0] oc1_threshold(input logic softstart, input logic exiting);
      if (softstart) begin
         oc1_threshold = OC1_TH_STARTUP;
      end else if (exiting) begin
         oc1_threshold = OC1_TH_BURST;
      end else begin
         oc1_threshold = OC1_TH_NORMAL;
      end
   endfunction : oc1_threshold
   // next-state logic
   always_comb begin
      logic hb_run;
      logic cycle_end;
      logic oc1_eval;
      logic oc1_trip;
      logic sys_fault;
      logic [PERIOD_W-1:0] base_period;
      logic pfc_run;
      logic pfc_start;
      hb_run = 1'b0;
      cycle_end = 1'b0;
      oc1_eval = 1'b0;
      oc1_trip = 1'b0;
      sys_fault = 1'b0;
      base_period = '0;
      pfc_run = 1'b0;
      pfc_start = 1'b0;
      next_q = q;
      // pins: three stages, accept when second and third agree
      next_q.sync1 = {bus_overvoltage_second, bus_overvoltage_first, correction_current_sense,
                      zero_crossing_detect, hb_overcurrent_level_two};
      next_q.sync2 = q.sync1;
      next_q.sync3 = q.sync2;
      for (int i = 0; i < PIN_N; i++) begin
         if (q.sync2[i] == q.sync3[i]) begin
            next_q.pin[i] = q.sync3[i];
         end
      end
      // initialization: load setup values, then enable both stages
      if (!q.init_done) begin
         next_q.oc1_period = oc1_limit_frequency;
         next_q.oc1_limit = (oc1_event_limit == '0) ? OC1_EVENT_LIMIT_DEFAULT : oc1_event_limit;
         next_q.min_on = correction_min_on_time;
         next_q.hb_start_lvl = hb_startup_bus_level;
         next_q.init_cnt = q.init_cnt + 5'h01;
         if (q.init_cnt == INIT_LOAD_CYCLES - 5'h01) begin
            next_q.init_done = 1'b1;
            next_q.hb_state = HB_BUS_CHECK;
            next_q.pfc_state = PFC_LOOP_CHECK;
         end
      end
      // level-two status: sticky, a new event wins over the clear
      if (q.pin[PIN_OC2]) begin
         next_q.oc2_event = 1'b1;
      end else if (oc2_event_clear) begin
         next_q.oc2_event = 1'b0;
      end
      // half-bridge oscillator runs in softstart and normal only
      hb_run = (q.hb_state == HB_SOFTSTART) || (q.hb_state == HB_NORMAL);
      if (hb_run) begin
         if (q.hb_cnt >= q.hb_period - 16'h1) begin
            next_q.hb_cnt = '0;
            next_q.hb_half = ~q.hb_half;
            cycle_end = q.hb_half;
         end else begin
            next_q.hb_cnt = q.hb_cnt + 16'h1;
         end
         next_q.hb_high = ~next_q.hb_half;
         next_q.hb_low = next_q.hb_half;
      end else begin
         next_q.hb_cnt = '0;
         next_q.hb_half = 1'b0;
         next_q.hb_high = 1'b0;
         next_q.hb_low = 1'b0;
      end
      // level-one evaluation once per switching cycle
      oc1_eval = cycle_end && ((q.hb_state == HB_SOFTSTART) || burst_exit || !burst_active);
      oc1_trip = oc1_eval && (hb_shunt_sense > oc1_threshold(q.hb_state == HB_SOFTSTART, burst_exit));
      base_period = (q.hb_state == HB_SOFTSTART) ? q.tco_period : hb_feedback_input;
      if (oc1_trip) begin
         next_q.oc1_active = 1'b1;
         next_q.oc1_run = q.oc1_period;
         next_q.oc1_count = q.oc1_count + 4'h1;
         if (q.oc1_count + 4'h1 >= q.oc1_limit) begin
            sys_fault = 1'b1;
         end
      end else if (q.oc1_active && cycle_end) begin
         if (base_period <= q.oc1_run) begin
            next_q.oc1_active = 1'b0;
            next_q.oc1_count = '0;
         end else begin
            next_q.oc1_run = sat_add(q.oc1_run, oc1_release_step);
         end
      end
      // period applied at each cycle boundary
      if (cycle_end || !hb_run) begin
         next_q.hb_period = next_q.oc1_active ? next_q.oc1_run : base_period;
      end
      // faults that stop the whole system
      if (hb_run && (q.pin[PIN_OC2] || hb_open_loop || hb_overload)) begin
         sys_fault = 1'b1;
      end
      // half-bridge state flow
      unique case (q.hb_state)
         HB_DISABLED: begin
            next_q.ss_timer = '0;
         end
         HB_BUS_CHECK: begin
            if (bus_voltage_sense >= q.hb_start_lvl) begin
               next_q.hb_state = HB_SOFTSTART;
               next_q.tco_period = tco_start_period;
               next_q.tco_step = tco_initial_step;
               next_q.hb_period = tco_start_period;
               next_q.ss_timer = '0;
            end
         end
         HB_SOFTSTART: begin
            if (q.ss_timer >= SS_STEP_LAST) begin
               next_q.ss_timer = '0;
               next_q.tco_period = sat_add(q.tco_period, q.tco_step);
               next_q.tco_step = ((q.tco_step >> 1) > tco_min_step) ? (q.tco_step >> 1) : tco_min_step;
            end else begin
               next_q.ss_timer = q.ss_timer + 27'h1;
            end
            if (hb_feedback_input <= q.tco_period) begin
               next_q.hb_state = HB_NORMAL;
            end
            if (bus_voltage_sense < hb_undervoltage_level) begin
               next_q.hb_state = HB_BUS_CHECK;
            end
         end
         HB_NORMAL: begin
            if (bus_voltage_sense < hb_undervoltage_level) begin
               next_q.hb_state = HB_BUS_CHECK;
            end
         end
         HB_RESTART: begin
            if (q.sys_pause >= RESTART_LAST) begin
               next_q.hb_state = HB_SOFTSTART;
               next_q.tco_period = tco_start_period;
               next_q.tco_step = tco_initial_step;
               next_q.hb_period = tco_start_period;
               next_q.ss_timer = '0;
               next_q.pfc_state = PFC_LOOP_CHECK;
            end else begin
               next_q.sys_pause = q.sys_pause + 27'h1;
            end
         end
         default: begin
            next_q.hb_state = HB_DISABLED;
         end
      endcase
      // correction pulse generation while switching is allowed
      pfc_run = (q.pfc_state == PFC_SOFTSTART) || (q.pfc_state == PFC_NORMAL);
      next_q.zcd_prev = q.pin[PIN_ZCD];
      if (pfc_run) begin
         if (q.pfc_gate) begin
            next_q.pfc_oc_cnt = q.pin[PIN_PFC_OC] ? q.pfc_oc_cnt + 5'h01 : 5'h00;
            if (q.pin[PIN_PFC_OC] && (q.pfc_oc_cnt >= OC_BLANK - 5'h01)) begin
               next_q.pfc_gate = 1'b0;
               next_q.pfc_off_cnt = '0;
            end else if (q.pfc_on_cnt <= 12'h001) begin
               next_q.pfc_gate = 1'b0;
               next_q.pfc_off_cnt = '0;
            end else begin
               next_q.pfc_on_cnt = q.pfc_on_cnt - 12'h001;
            end
         end else begin
            next_q.pfc_oc_cnt = '0;
            pfc_start = (q.pin[PIN_ZCD] && !q.zcd_prev) || (q.pfc_off_cnt >= PFC_MAX_PERIOD - 12'h001);
            if (pfc_start) begin
               next_q.pfc_off_cnt = '0;
               if (correction_on_request >= q.min_on) begin
                  next_q.pfc_gate = 1'b1;
                  next_q.pfc_on_cnt = correction_on_request;
               end
               // a short request leaves the gate low for this cycle
            end else begin
               next_q.pfc_off_cnt = q.pfc_off_cnt + 12'h001;
            end
         end
      end else begin
         next_q.pfc_gate = 1'b0;
         next_q.pfc_on_cnt = '0;
         next_q.pfc_off_cnt = '0;
         next_q.pfc_oc_cnt = '0;
      end
      // correction state flow
      unique case (q.pfc_state)
         PFC_DISABLED: begin
            next_q.pfc_pause = '0;
         end
         PFC_LOOP_CHECK: begin
            if (bus_voltage_sense >= bus_open_loop_level) begin
               next_q.pfc_state = PFC_SOFTSTART;
            end
         end
         PFC_SOFTSTART: begin
            if (bus_voltage_sense >= bus_near_rated_level) begin
               next_q.pfc_state = PFC_NORMAL;
            end
         end
         PFC_NORMAL: begin
            next_q.pfc_state = PFC_NORMAL;
         end
         PFC_OV_PAUSE: begin
            if (!q.pin[PIN_BUS_OVERVOLTAGE_FIRST] && !q.pin[PIN_BUS_OVERVOLTAGE_SECOND]) begin
               next_q.pfc_state = PFC_NORMAL;
            end
         end
         PFC_RESTART: begin
            if (q.pfc_pause >= RESTART_LAST) begin
               next_q.pfc_state = PFC_LOOP_CHECK;
            end else begin
               next_q.pfc_pause = q.pfc_pause + 27'h1;
            end
         end
         default: begin
            next_q.pfc_state = PFC_DISABLED;
         end
      endcase
      if (pfc_run && (q.pin[PIN_BUS_OVERVOLTAGE_FIRST] || q.pin[PIN_BUS_OVERVOLTAGE_SECOND])) begin
         next_q.pfc_state = PFC_OV_PAUSE;
         next_q.pfc_gate = 1'b0;
      end
      if (pfc_run && correction_ccm_fault) begin
         next_q.pfc_state = PFC_RESTART;
         next_q.pfc_pause = '0;
         next_q.pfc_gate = 1'b0;
      end
      // system auto-restart stops both stages and starts the pause
      if (sys_fault) begin
         next_q.hb_state = HB_RESTART;
         next_q.sys_pause = '0;
         next_q.oc1_active = 1'b0;
         next_q.oc1_count = '0;
         next_q.hb_high = 1'b0;
         next_q.hb_low = 1'b0;
         next_q.pfc_state = PFC_RESTART;
         next_q.pfc_pause = '0;
         next_q.pfc_gate = 1'b0;
      end
   end

   // single state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // outputs straight from state
   assign hb_high_gate = q.hb_high;
   assign hb_low_gate = q.hb_low;
   assign hb_sense_enable = (q.hb_state != HB_DISABLED) && (q.hb_state != HB_RESTART);
   assign hb_switch_period = q.hb_period;
   assign hb_oc1_limiting = q.oc1_active;
   assign hb_oc2_status = q.pin[PIN_OC2];
   assign hb_oc2_event = q.oc2_event;
   assign correction_gate = q.pfc_gate;
   assign correction_sense_enable = (q.pfc_state != PFC_DISABLED) && (q.pfc_state != PFC_RESTART);
   assign correction_integrator_limit = (q.pfc_state == PFC_SOFTSTART);
   assign system_restart_active = (q.hb_state == HB_RESTART);
endmodule : pfc_llc_protection_sequencer

/* verification/pfc_llc_seq_sva.sv */
`timescale 1ns/1ps
module pfc_llc_seq_sva #(
   parameter int RESTART_PAUSE_CYCLES = 50
) (
   input logic clk,
   input logic rst_n,
   input logic hb_overcurrent_level_two,
   input logic bus_overvoltage_first,
   input logic [pfc_llc_seq_pkg::ONTIME_W-1:0] correction_on_request,
   input logic [pfc_llc_seq_pkg::ONTIME_W-1:0] correction_min_on_time,
   input logic [pfc_llc_seq_pkg::PERIOD_W-1:0] oc1_limit_frequency,
   input logic hb_high_gate,
   input logic hb_low_gate,
   input logic hb_sense_enable,
   input logic [pfc_llc_seq_pkg::PERIOD_W-1:0] hb_switch_period,
   input logic hb_oc1_limiting,
   input logic hb_oc2_status,
   input logic hb_oc2_event,
   input logic correction_gate,
   input logic correction_sense_enable,
   input logic correction_integrator_limit,
   input logic system_restart_active
);
   import pfc_llc_seq_pkg::*;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic [31:0] pause_cnt; // cycles spent in the restart pause
   // length of the current restart pause
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pause_cnt <= '0;
      else pause_cnt <= system_restart_active ? pause_cnt + 32'h1 : '0;
   end
   a_hb_idle_gates: assert property (!hb_sense_enable |-> !hb_high_gate && !hb_low_gate)
      else $error("hb gate while idle");
   a_pfc_idle_gate: assert property (!correction_sense_enable |-> !correction_gate)
      else $error("pfc gate while idle");
   a_restart_gates: assert property (system_restart_active |-> !hb_high_gate && !hb_low_gate && !correction_gate)
      else $error("gate in restart");
   a_pause_bound: assert property (pause_cnt <= RESTART_PAUSE_CYCLES)
      else $error("pause too long");
   a_oc2_restart: assert property ($rose(hb_oc2_status) && hb_sense_enable |-> ##[0:2] system_restart_active)
      else $error("no restart on trip");
   a_oc2_sticky: assert property (hb_oc2_status |=> hb_oc2_event)
      else $error("event not latched");
   a_oc2_filter: assert property (hb_overcurrent_level_two [*7] |-> hb_oc2_status)
      else $error("status missing");
   a_limit_period: assert property ($rose(hb_oc1_limiting) |-> hb_switch_period == oc1_limit_frequency)
      else $error("limit not imposed");
   a_release_up: assert property (hb_oc1_limiting && $past(hb_oc1_limiting) |->
      hb_switch_period >= $past(hb_switch_period) || hb_switch_period == oc1_limit_frequency)
      else $error("period shrank");
   a_ov_pause: assert property (bus_overvoltage_first [*7] |-> !correction_gate)
      else $error("gate in overvoltage");
   a_min_on: assert property ($rose(correction_gate) |-> $past(correction_on_request) >= correction_min_on_time)
      else $error("short pulse");
   a_integ_soft: assert property (correction_integrator_limit |-> correction_sense_enable)
      else $error("limit outside softstart");
   c_limit: cover property ($rose(hb_oc1_limiting));
   c_restart: cover property ($rose(system_restart_active));
   c_pulse: cover property ($rose(correction_gate));
endmodule : pfc_llc_seq_sva

/* verification/power_stage_model.sv */
`timescale 1ns/1ps
module power_stage_model #(
   parameter int OC2_LEVEL = 32'h7d0 // level-two comparator trip code
) (
   input logic clk,
   input logic hb_low_gate,
   input logic correction_gate,
   input logic [pfc_llc_seq_pkg::SENSE_W-1:0] shunt_level,
   output logic [pfc_llc_seq_pkg::SENSE_W-1:0] hb_shunt_sense,
   output logic hb_overcurrent_level_two,
   output logic zero_crossing_detect
);
   import pfc_llc_seq_pkg::*;
   logic [7:0] gate_hist = '0; // recent correction gate levels
   // shunt reads its level while the low side conducts, the inverted level otherwise
   assign hb_shunt_sense = hb_low_gate ? shunt_level : ~shunt_level;
   assign hb_overcurrent_level_two = hb_low_gate && (32'(shunt_level) > OC2_LEVEL);
   // valley shows a few cycles after the choke demagnetises
   assign zero_crossing_detect = gate_hist[7] & ~gate_hist[3];
   always @(posedge clk) begin
      gate_hist <= {gate_hist[6:0], correction_gate};
   end
endmodule : power_stage_model

/* verification/pfc_llc_protection_sequencer_test.sv */
`timescale 1ns/1ps
module pfc_llc_protection_sequencer_test;
   import pfc_llc_seq_pkg::*;
   localparam int PAUSE = 50; // shortened restart pause
   logic clk, rst_n, zero_crossing_detect, correction_current_sense, bus_overvoltage_first;
   logic bus_overvoltage_second, hb_overcurrent_level_two, burst_active, burst_exit, hb_open_loop;
   logic hb_overload, correction_ccm_fault, oc2_event_clear, hb_high_gate, hb_low_gate, hb_sense_enable;
   logic hb_oc1_limiting, hb_oc2_status, hb_oc2_event, correction_gate, correction_sense_enable;
   logic correction_integrator_limit, system_restart_active;
   logic [SENSE_W-1:0] hb_shunt_sense, bus_voltage_sense, hb_startup_bus_level, hb_undervoltage_level;
   logic [SENSE_W-1:0] bus_open_loop_level, bus_near_rated_level, shunt_level;
   logic [PERIOD_W-1:0] hb_feedback_input, oc1_limit_frequency, oc1_release_step, tco_start_period;
   logic [PERIOD_W-1:0] tco_initial_step, tco_min_step, hb_switch_period;
   logic [ONTIME_W-1:0] correction_on_request, correction_min_on_time;
   logic [EVT_W-1:0] oc1_event_limit;
   int fail_count, checks, cycles, n;
   pfc_llc_protection_sequencer #(.SS_STEP_CYCLES(20), .RESTART_PAUSE_CYCLES(PAUSE)) dut_u (.*);
   power_stage_model model_u (.*);
   task automatic check(input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      if (fail_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   // outputs quiet during setup, both stages live afterwards
   task automatic init_case();
      repeat (14) @(negedge clk);
      check({hb_sense_enable, correction_sense_enable, hb_low_gate, correction_gate}, 4'h0);
      repeat (6) @(negedge clk);
      check({hb_sense_enable, correction_sense_enable}, 2'b11);
   endtask : init_case
   // sit on a phase threshold, step one code over, then release
   task automatic threshold_case(input logic ba, input logic be, input logic [SENSE_W-1:0] th);
      {burst_active, burst_exit, shunt_level} = {ba, be, th};
      repeat (300) @(negedge clk);
      check(hb_oc1_limiting, 1'b0);
      shunt_level = th + 12'h001;
      for (int i = 0; i < 300 && hb_oc1_limiting !== 1'b1; i++) @(negedge clk);
      check(hb_oc1_limiting, 1'b1);
      check(hb_switch_period, oc1_limit_frequency);
      shunt_level = '0;
      for (int i = 0; i < 1000 && hb_oc1_limiting !== 1'b0; i++) @(negedge clk);
      check(hb_oc1_limiting, 1'b0);
   endtask : threshold_case
   // held overcurrent counts up to the default limit of eight
   task automatic count_case();
      {burst_active, burst_exit, shunt_level} = {2'b00, 12'h358};
      for (int i = 0; i < 300 && hb_oc1_limiting !== 1'b1; i++) @(negedge clk);
      repeat (180) @(negedge clk);
      check(system_restart_active, 1'b0);
      for (int i = 0; i < 400 && system_restart_active !== 1'b1; i++) @(negedge clk);
      check(system_restart_active, 1'b1);
      shunt_level = '0;
      for (n = 0; n < 200 && system_restart_active === 1'b1; n++) @(negedge clk);
      check(n, PAUSE);
      check(hb_sense_enable, 1'b1);
   endtask : count_case
   // level-two comparator trip, sticky flag and its clear
   task automatic oc2_case();
      repeat (300) @(negedge clk);
      shunt_level = 12'h7d1;
      for (int i = 0; i < 300 && hb_oc2_status !== 1'b1; i++) @(negedge clk);
      check(hb_oc2_status, 1'b1);
      repeat (3) @(negedge clk);
      check({system_restart_active, hb_oc2_event}, 2'b11);
      shunt_level = '0;
      repeat (10) @(negedge clk);
      oc2_event_clear = 1'b1;
      @(negedge clk);
      oc2_event_clear = 1'b0;
      @(negedge clk);
      check(hb_oc2_event, 1'b0);
   endtask : oc2_case
   // on-time floor, pulse width, overvoltage, conduction fault
   task automatic correction_case();
      logic seen;
      seen = 1'b0;
      correction_on_request = 12'h01f;
      repeat (3000) begin
         @(negedge clk);
         seen |= correction_gate;
      end
      check(seen, 1'b0);
      correction_on_request = 12'h020;
      for (int i = 0; i < 3000 && correction_gate !== 1'b1; i++) @(negedge clk);
      for (n = 0; n < 100 && correction_gate === 1'b1; n++) @(negedge clk);
      check(n, 32'h20);
      bus_overvoltage_first = 1'b1;
      repeat (3000) @(negedge clk);
      check(correction_sense_enable, 1'b1);
      bus_overvoltage_first = 1'b0;
      for (int i = 0; i < 3000 && correction_gate !== 1'b1; i++) @(negedge clk);
      check(correction_gate, 1'b1);
      correction_ccm_fault = 1'b1;
      repeat (10) @(negedge clk);
      check({correction_sense_enable, hb_sense_enable}, 2'b01);
      correction_ccm_fault = 1'b0;
      repeat (200) @(negedge clk);
      check(correction_sense_enable, 1'b1);
   endtask : correction_case
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // cut a hung run short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         finish_test();
      end
   end
   // main sequence
   initial begin
      {rst_n, correction_current_sense, bus_overvoltage_first, bus_overvoltage_second, burst_active} = '0;
      {burst_exit, hb_open_loop, hb_overload, correction_ccm_fault, oc2_event_clear, shunt_level} = '0;
      {bus_voltage_sense, hb_startup_bus_level, hb_undervoltage_level} = {12'h800, 12'h400, 12'h200};
      {bus_open_loop_level, bus_near_rated_level, correction_on_request} = {12'h100, 12'h700, 12'h040};
      {hb_feedback_input, oc1_limit_frequency, oc1_release_step} = {16'hffff, 16'h0010, 16'h0010};
      {tco_start_period, tco_initial_step, tco_min_step} = {16'h0010, 16'h0008, 16'h0001};
      {correction_min_on_time, oc1_event_limit} = {12'h020, 4'h0};
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      init_case();
      threshold_case(1'b0, 1'b0, 12'h44c);
      hb_feedback_input = 16'h0020;
      repeat (300) @(negedge clk);
      check(hb_switch_period, 16'h0020);
      threshold_case(1'b0, 1'b0, 12'h357);
      threshold_case(1'b1, 1'b1, 12'h5dc);
      count_case();
      oc2_case();
      correction_case();
      finish_test();
   end
endmodule : pfc_llc_protection_sequencer_test
bind pfc_llc_protection_sequencer pfc_llc_seq_sva #(.RESTART_PAUSE_CYCLES(RESTART_PAUSE_CYCLES)) sva_u (.*);
